// *** logic/acr_ctl.sv ***
// converter control register with wishbone slave and enable sequencing
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
module acr_ctl #(
  parameter int REC_CYCLES = acr_pkg::REC_CYC,
  parameter int DIS_CYCLES = acr_pkg::DIS_CYC,
  parameter int SR_CYCLES  = acr_pkg::SR_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [1:0]  sel_i,
  input  wire logic [15:0] dat_i,
  output logic [15:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // converter side
  input  wire logic        special_mode_i,
  input  wire logic        freeze_mode_i,
  input  wire logic        wait_mode_i,
  input  wire logic        conv_boundary_i,
  input  wire logic        severe_error_i,
  input  wire logic        actions_busy_i,
  output logic             power_on_o,
  output logic             trigger_allow_o,
  output logic             conv_run_o,
  output logic             abort_seq_o,
  output logic             discard_results_o,
  output logic             clear_flags_o,
  output logic             clear_indices_o,
  output logic             path_internal_o,
  output logic             path_bus_o,
  output logic             restart_mode_o,
  output logic             trigger_mode_o,
  output logic             store_on_abort_o
);
  localparam int TW = 12;

  // refuse wait counts that the timer cannot hold
  if (REC_CYCLES < 1 || REC_CYCLES >= (1 << TW)) begin : g_bad_rec
    $error("recovery count out of range");
  end
  if (DIS_CYCLES < 1 || DIS_CYCLES >= (1 << TW)) begin : g_bad_dis
    $error("disable count out of range");
  end
  if (SR_CYCLES < 1 || SR_CYCLES >= (1 << TW)) begin : g_bad_sr
    $error("soft reset count out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    acr_pkg::acr_ctl_s   ctl;
    acr_pkg::acr_state_e fsm;
    logic                halted;
    logic                stopped;
    logic                ack;
    logic                err;
    logic [15:0]         rdat;
    logic                abort;
    logic                sr_pulse;
  } acr_st_s;
  acr_st_s st;
  acr_st_s next_st;

  logic          tmr_load;
  logic [TW-1:0] tmr_count;
  logic          tmr_done;

  // pack control fields into the register image
  function automatic logic [15:0] ctl_image(input acr_pkg::acr_ctl_s c);
    logic [15:0] v;
    v = acr_pkg::CTL0_RESET;
    v[acr_pkg::BIT_EN]    = c.en;
    v[acr_pkg::BIT_SR]    = c.sr;
    v[acr_pkg::BIT_FRZ]   = c.frz;
    v[acr_pkg::BIT_WAI]   = c.wai;
    v[acr_pkg::BIT_PATH_HI:acr_pkg::BIT_PATH_LO] = c.path;
    v[acr_pkg::BIT_STORE] = c.store;
    v[acr_pkg::BIT_MODE]  = c.mode;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // wait timer
  // ----------------------------------------------------------------
  acr_timer #(.WIDTH(TW)) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  logic req;
  logic wr_hit;
  logic [15:0] wmask;
  logic [15:0] wv;
  assign req   = cyc_i && stb_i && !st.ack && !st.err;
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wv    = (dat_i & wmask) | (ctl_image(st.ctl) & ~wmask);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.ack      = 1'b0;
    next_st.err      = 1'b0;
    next_st.abort    = 1'b0;
    next_st.sr_pulse = 1'b0;
    tmr_load         = 1'b0;
    tmr_count        = '0;
    wr_hit           = 1'b0;
    // bus decode and read capture
    if (req) begin
      if (adr_i == acr_pkg::ADDR_CTL0) begin
        next_st.ack  = 1'b1;
        next_st.rdat = ctl_image(st.ctl);
        wr_hit       = we_i;
      end else if (adr_i == acr_pkg::ADDR_STATUS) begin
        next_st.ack  = 1'b1;
        next_st.rdat = {11'h000, st.stopped, st.halted, 3'(st.fsm)};
      end else begin
        next_st.err  = 1'b1;
      end
    end
    // register writes
    if (wr_hit) begin
      next_st.ctl.en  = wv[acr_pkg::BIT_EN];
      next_st.ctl.frz = wv[acr_pkg::BIT_FRZ];
      next_st.ctl.wai = wv[acr_pkg::BIT_WAI];
      if (!st.ctl.sr && wv[acr_pkg::BIT_SR]) begin
        next_st.ctl.sr = 1'b1; // only a set; clear ignored
      end
      if (!st.ctl.en || special_mode_i) begin
        next_st.ctl.path  = wv[acr_pkg::BIT_PATH_HI:acr_pkg::BIT_PATH_LO];
        next_st.ctl.store = wv[acr_pkg::BIT_STORE];
        next_st.ctl.mode  = wv[acr_pkg::BIT_MODE];
      end // blocked bits keep their value
    end
    // severe error latches a stop
    if (severe_error_i) begin
      next_st.stopped = 1'b1;
    end
    // freeze and wait halting at boundaries
    if (conv_boundary_i && ((freeze_mode_i && st.ctl.frz) || (wait_mode_i && st.ctl.wai))) begin
      next_st.halted = 1'b1;
    end else if (!(freeze_mode_i && st.ctl.frz) && !(wait_mode_i && st.ctl.wai)) begin
      next_st.halted = 1'b0;
    end
    // enable sequencing
    case (st.fsm)
      acr_pkg::ST_OFF: begin
        if (next_st.ctl.en) begin
          next_st.fsm = acr_pkg::ST_RECOVER;
          tmr_load    = 1'b1;
          tmr_count   = TW'(REC_CYCLES);
        end
      end
      acr_pkg::ST_RECOVER, acr_pkg::ST_READY: begin
        if (st.fsm == acr_pkg::ST_RECOVER && tmr_done) begin
          next_st.fsm = acr_pkg::ST_READY;
        end
        if (!next_st.ctl.en) begin
          next_st.fsm   = acr_pkg::ST_DISABLING;
          next_st.abort = 1'b1;
          tmr_load      = 1'b1;
          tmr_count     = TW'(DIS_CYCLES);
        end
      end
      acr_pkg::ST_DISABLING: begin
        if (tmr_done || !actions_busy_i) begin
          next_st.fsm = acr_pkg::ST_OFF;
        end
      end
      acr_pkg::ST_SOFTRST: begin
        if (tmr_done) begin
          next_st.ctl.sr = 1'b0; // hardware clear
          next_st.fsm    = acr_pkg::ST_OFF;
        end
      end
      default: begin
        next_st.fsm = acr_pkg::ST_OFF;
      end
    endcase
    // soft reset takes priority over sequencing
    if (next_st.ctl.sr && !st.ctl.sr) begin
      next_st.fsm      = acr_pkg::ST_SOFTRST;
      next_st.sr_pulse = 1'b1;
      next_st.stopped  = severe_error_i; // a stop raised in this cycle survives
      next_st.halted   = 1'b0;
      next_st.abort    = 1'b1;
      tmr_load         = 1'b1;
      tmr_count        = TW'(SR_CYCLES);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st     <= '0;
      st.fsm <= acr_pkg::ST_OFF;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dat_o             = st.rdat;
  assign ack_o             = st.ack;
  assign err_o             = st.err;
  assign power_on_o        = st.ctl.en;
  assign trigger_allow_o   = (st.fsm == acr_pkg::ST_READY) && !st.stopped;
  assign conv_run_o        = trigger_allow_o && !st.halted;
  assign abort_seq_o       = st.abort;
  assign discard_results_o = st.abort && !st.ctl.sr;
  assign clear_flags_o     = st.sr_pulse;
  assign clear_indices_o   = st.sr_pulse;
  assign path_internal_o   = (st.ctl.path == acr_pkg::PATH_INT) || (st.ctl.path == acr_pkg::PATH_BOTH);
  assign path_bus_o        = (st.ctl.path == acr_pkg::PATH_BUS) || (st.ctl.path == acr_pkg::PATH_BOTH);
  assign restart_mode_o    = !st.ctl.mode;
  assign trigger_mode_o    = st.ctl.mode;
  assign store_on_abort_o  = st.ctl.store;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_gated_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctl.en && !special_mode_i) |=> $stable(st.ctl.path) && $stable(st.ctl.mode) && $stable(st.ctl.store))
    else $error("gated bits changed while enabled");
  chk_sr_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctl.sr && st.fsm == acr_pkg::ST_SOFTRST && !tmr_done) |=> st.ctl.sr)
    else $error("soft reset bit cleared early");
  chk_disable_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(st.ctl.en) && !st.ctl.sr && ($past(st.fsm) == acr_pkg::ST_RECOVER || $past(st.fsm) == acr_pkg::ST_READY)
    |-> abort_seq_o && discard_results_o)
    else $error("disable did not abort");
  chk_no_fast_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.fsm == acr_pkg::ST_DISABLING) |-> !trigger_allow_o &&
      (!actions_busy_i || tmr_done || next_st.fsm == acr_pkg::ST_DISABLING || next_st.ctl.sr))
    else $error("enabled while disabling");
  chk_recover_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.fsm == acr_pkg::ST_RECOVER) |-> !trigger_allow_o [*2])
    else $error("trigger allowed during recovery");
  chk_sr_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.ctl.sr) |-> clear_flags_o && clear_indices_o && st.fsm == acr_pkg::ST_SOFTRST)
    else $error("soft reset did not clear");
  chk_stop_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    st.stopped && !$rose(st.ctl.sr) |=> !trigger_allow_o || $rose(st.ctl.sr))
    else $error("stopped converter running");
  chk_path_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctl.path == acr_pkg::PATH_NONE) |-> !path_internal_o && !path_bus_o)
    else $error("path decode wrong");
  chk_freeze_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_boundary_i && freeze_mode_i && st.ctl.frz && !next_st.ctl.sr) |=> !conv_run_o)
    else $error("freeze did not halt");
  chk_wait_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_boundary_i && wait_mode_i && st.ctl.wai && !next_st.ctl.sr) |=> !conv_run_o)
    else $error("wait did not halt");
  cov_enable_ready: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st.fsm == acr_pkg::ST_READY));
  cov_soft_reset: cover property (@(posedge clk_i) disable iff (rst_i) $fell(st.ctl.sr));
  cov_blocked_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_hit && st.ctl.en && !special_mode_i);
  chk_path_both: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctl.path == acr_pkg::PATH_BOTH) |-> path_internal_o && path_bus_o)
    else $error("dual path decode wrong");
  chk_path_single: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ctl.path == acr_pkg::PATH_INT || st.ctl.path == acr_pkg::PATH_BUS) |-> path_internal_o != path_bus_o)
    else $error("single path decode wrong");
  chk_mode_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    trigger_mode_o == st.ctl.mode && restart_mode_o == !st.ctl.mode)
    else $error("flow mode decode wrong");
  chk_anytime_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_hit && wv[acr_pkg::BIT_FRZ] && wv[acr_pkg::BIT_WAI]) |=> st.ctl.frz && st.ctl.wai)
    else $error("anytime bits not written");
  chk_clear_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_indices_o |=> !clear_indices_o && st.fsm == acr_pkg::ST_SOFTRST)
    else $error("index clear not a single pulse");
  cov_freeze_halt: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st.halted));
  cov_disable_abort: cover property (@(posedge clk_i) disable iff (rst_i) discard_results_o);
endmodule

// *** logic/acr_pkg.sv ***
// constants, types and field layout for the converter control register block
package acr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTL0     = 8'h00; // converter_control_0
  localparam logic [7:0]  ADDR_STATUS   = 8'h04; // block state readback
  localparam logic [15:0] CTL0_RESET    = 16'h0000;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_EN      = 15;
  localparam int BIT_SR      = 14;
  localparam int BIT_FRZ     = 13;
  localparam int BIT_WAI     = 12;
  localparam int BIT_PATH_HI = 11;
  localparam int BIT_PATH_LO = 10;
  localparam int BIT_STORE   = 9;
  localparam int BIT_MODE    = 8;
  localparam logic [15:0] MASK_ANYTIME = 16'hf000;
  localparam logic [15:0] MASK_GATED   = 16'h0f00;
  localparam logic [1:0]  PATH_NONE = 2'h0;
  localparam logic [1:0]  PATH_INT  = 2'h1;
  localparam logic [1:0]  PATH_BUS  = 2'h2;
  localparam logic [1:0]  PATH_BOTH = 2'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 50;
  localparam int REC_NS        = 1000;
  localparam int DIS_NS        = 2000;
  localparam int REC_CYC       = (REC_NS * CLK_MHZ + 999) / 1000;
  localparam int DIS_CYC       = (DIS_NS * CLK_MHZ + 999) / 1000;
  localparam int SR_CYC        = 4;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_OFF, ST_RECOVER, ST_READY, ST_DISABLING, ST_SOFTRST} acr_state_e;
  typedef struct packed {
    logic        en;
    logic        sr;
    logic        frz;
    logic        wai;
    logic [1:0]  path;
    logic        store;
    logic        mode;
  } acr_ctl_s;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [1:0]  sel;
    logic [15:0] dat;
  } acr_wb_req_s;
endpackage

// *** logic/acr_timer.sv ***
// down counter used for recovery, disable and soft reset waits
`timescale 1ns/10ps
module acr_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  done_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } acr_tmr_s;
  acr_tmr_s st;
  acr_tmr_s next_st;

  // refuse a counter too narrow to count down
  if (WIDTH < 2) begin : g_bad_width
    $error("acr_timer width too small");
  end

  // load or count down toward zero
  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.cnt = count_i;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = (st.cnt == '0) && !load_i;
endmodule

// *** verif/acr_ctl_tb.sv ***
// self-checking testbench for the converter control register block
`timescale 1ns/10ps
module acr_ctl_tb;
  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  localparam int REC = 4;
  localparam int DIS = 20;
  localparam int SRC = 12;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o;
  logic [7:0]  adr_i;
  logic [1:0]  sel_i;
  logic [15:0] dat_i, dat_o, rd;
  logic        special_mode_i, freeze_mode_i, wait_mode_i, conv_boundary_i, severe_error_i, actions_busy_i;
  logic        power_on_o, trigger_allow_o, conv_run_o, abort_seq_o, discard_results_o, clear_flags_o;
  logic        clear_indices_o, path_internal_o, path_bus_o, restart_mode_o, trigger_mode_o, store_on_abort_o, e;
  int          n_errors, cmp_count, n_abort, n_disc, n_clrf, n_clri, i, k, a0, d0;

  acr_ctl #(.REC_CYCLES(REC), .DIS_CYCLES(DIS), .SR_CYCLES(SRC)) dut_u (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
    .special_mode_i, .freeze_mode_i, .wait_mode_i, .conv_boundary_i, .severe_error_i, .actions_busy_i,
    .power_on_o, .trigger_allow_o, .conv_run_o, .abort_seq_o, .discard_results_o, .clear_flags_o,
    .clear_indices_o, .path_internal_o, .path_bus_o, .restart_mode_o, .trigger_mode_o, .store_on_abort_o);

  // clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // pulse counters for one-cycle outputs
  always @(posedge clk_i) begin
    if (abort_seq_o === 1'b1) n_abort++;
    if (discard_results_o === 1'b1) n_disc++;
    if (clear_flags_o === 1'b1) n_clrf++;
    if (clear_indices_o === 1'b1) n_clri++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack or err is sampled high; only the watchdog ends the wait
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [1:0] s, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb_xfer(1'b1, a, 2'b11, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    wb_xfer(1'b0, a, 2'b11, 16'h0000);
    chk16(rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one-cycle conversion boundary, then settle
  task automatic pulse_boundary;
    conv_boundary_i <= 1'b1;
    tick(1);
    conv_boundary_i <= 1'b0;
    tick(3);
  endtask

  // bounded wait for the trigger permission
  task automatic wait_allow(input int lim);
    for (i = 0; i < lim && trigger_allow_o !== 1'b1; i++) @(posedge clk_i);
    chk1(trigger_allow_o, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(5000);
    n_errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    final_report;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {special_mode_i, freeze_mode_i, wait_mode_i, conv_boundary_i, severe_error_i, actions_busy_i} = '0;
    rst_i = 1'b1;
    tick(6);
    rst_i <= 1'b0;
    rd_chk(acr_pkg::ADDR_CTL0, acr_pkg::CTL0_RESET);
    chk1(path_internal_o | path_bus_o, 1'b0);
    chk1(restart_mode_o, 1'b1);
    // every path code and both flow modes while disabled
    for (k = 0; k < 4; k++) begin
      wr(acr_pkg::ADDR_CTL0, {4'h0, 2'(k), 1'b1, k[0], 8'h00});
      rd_chk(acr_pkg::ADDR_CTL0, {4'h0, 2'(k), 1'b1, k[0], 8'h00});
      chk1(path_internal_o, k[0]);
      chk1(path_bus_o, k[1]);
      chk1(trigger_mode_o, k[0]);
      chk1(restart_mode_o, ~k[0]);
      chk1(store_on_abort_o, 1'b1);
    end
    // enable, then recovery hold-off
    wr(acr_pkg::ADDR_CTL0, 16'h8f00);
    chk1(power_on_o, 1'b1);
    chk1(trigger_allow_o, 1'b0);
    wait_allow(REC + 10);
    rd_chk(acr_pkg::ADDR_STATUS, 16'h0002);
    // gated bits blocked while enabled, anytime bits still land
    wr(acr_pkg::ADDR_CTL0, 16'hb000);
    rd_chk(acr_pkg::ADDR_CTL0, 16'hbf00);
    chk1(store_on_abort_o, 1'b1);
    special_mode_i <= 1'b1;
    wr(acr_pkg::ADDR_CTL0, 16'hb500);
    rd_chk(acr_pkg::ADDR_CTL0, 16'hb500);
    chk1(store_on_abort_o, 1'b0);
    special_mode_i <= 1'b0;
    chk1(conv_run_o, 1'b1);
    // freeze (k=0) and wait (k=1) halts at the boundary
    for (k = 0; k < 2; k++) begin
      freeze_mode_i <= (k == 0);
      wait_mode_i   <= (k == 1);
      tick(3);
      chk1(conv_run_o, 1'b1);
      pulse_boundary;
      chk1(conv_run_o, 1'b0);
      rd_chk(acr_pkg::ADDR_STATUS, 16'h000a);
      freeze_mode_i <= 1'b0;
      wait_mode_i   <= 1'b0;
      tick(3);
      chk1(conv_run_o, 1'b1);
    end
    // selects at 0 keep converting
    wr(acr_pkg::ADDR_CTL0, 16'h8500);
    freeze_mode_i <= 1'b1;
    wait_mode_i   <= 1'b1;
    tick(2);
    pulse_boundary;
    chk1(conv_run_o, 1'b1);
    freeze_mode_i <= 1'b0;
    wait_mode_i   <= 1'b0;
    // severe error stops until soft reset
    severe_error_i <= 1'b1;
    tick(1);
    severe_error_i <= 1'b0;
    tick(12);
    chk1(trigger_allow_o, 1'b0);
    wr(acr_pkg::ADDR_CTL0, 16'hc500);
    wr(acr_pkg::ADDR_CTL0, 16'h8500);
    rd_chk(acr_pkg::ADDR_CTL0, 16'hc500);
    chk16(16'(n_clrf), 16'h0001);
    chk16(16'(n_clri), 16'h0001);
    for (k = 0; k < 10 && rd[14] !== 1'b0; k++) begin
      wb_xfer(1'b0, acr_pkg::ADDR_CTL0, 2'b11, 16'h0000);
    end
    chk16(rd, 16'h8500);
    wait_allow(REC + 30);
    // disable with actions busy, early re-enable waits
    actions_busy_i <= 1'b1;
    a0 = n_abort;
    d0 = n_disc;
    wr(acr_pkg::ADDR_CTL0, 16'h0500);
    chk1(power_on_o, 1'b0);
    wr(acr_pkg::ADDR_CTL0, 16'h8500);
    rd_chk(acr_pkg::ADDR_STATUS, 16'h0003);
    chk1(trigger_allow_o, 1'b0);
    chk16(16'(n_abort - a0), 16'h0001);
    chk16(16'(n_disc - d0), 16'h0001);
    actions_busy_i <= 1'b0;
    wait_allow(DIS + REC + 20);
    // unmapped address and a lane that misses the control bits
    wb_xfer(1'b1, 8'h08, 2'b11, 16'h0000);
    chk1(e, 1'b1);
    wb_xfer(1'b1, acr_pkg::ADDR_CTL0, 2'b01, 16'h0000);
    chk1(e, 1'b0);
    rd_chk(acr_pkg::ADDR_CTL0, 16'h8500);
    final_report;
  end
endmodule
